// >>> design/hst_map.svh
// Offsets, field positions, reset values and timing constants of the
// serdes tuning bank. Included by the package and the register bank module.
`ifndef HST_MAP_SVH
`define HST_MAP_SVH

// Register indices, as the management side addresses them
`define HST_OFS_SWING 8'h03
`define HST_OFS_RX_TUNING 8'h04
`define HST_OFS_TX_TAP 8'h05

// Reset values
`define HST_RST_SWING 16'hA848
`define HST_RST_RX_TUNING 16'h1500
`define HST_RST_TX_TAP 16'h2000

// Swing control register fields
`define HST_SWING_HI 15
`define HST_SWING_LO 12

// Receiver tuning register fields
`define HST_TRACK_BIT 15
`define HST_EQPRE_HI 14
`define HST_EQPRE_LO 12
`define HST_ORDER_HI 11
`define HST_ORDER_LO 10
`define HST_VOTE_HI 9
`define HST_VOTE_LO 8
`define HST_RX_RSVD_BIT 7
`define HST_PEAK_BIT 6
`define HST_SHORT_BIT 5
`define HST_CRF_HI 4
`define HST_CRF_LO 0

// Transmit tap register fields
`define HST_RXPOL_BIT 15
`define HST_TXPOL_BIT 14
`define HST_TX_RSVD_BIT 13
`define HST_POST1_HI 12
`define HST_POST1_LO 8
`define HST_PRE_HI 7
`define HST_PRE_LO 4
`define HST_POST2_HI 3
`define HST_POST2_LO 0

// Decode constants
`define HST_EQ_OFF_CODE 3'h7
`define HST_ORDER_RSVD 2'h3
`define HST_CRF_RSVD_LO 5'h07
`define HST_CRF_RSVD_HI 5'h0F
`define HST_SWING_MV_HI_BASE 4'hC

// Read data latency in clock cycles
`define HST_RD_LAT 1

`endif

// >>> design/hst_pkg.sv
// Types of the serdes tuning bank.
// Assumes hst_map.svh is compiled beside it.
`include "hst_map.svh"

package hst_pkg;

  // Recovery loop order modes
  typedef enum logic [1:0] {
    HST_ORD_FIRST = 2'b00,
    HST_ORD_SEC_1X = 2'b01,
    HST_ORD_SEC_2X = 2'b10,
    HST_ORD_RSVD = 2'b11
  } hst_order_e;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } hst_req_s;

  // Tuning settings toward the analog transceiver
  typedef struct packed {
    logic [3:0] tx_swing_level;
    logic rx_adc_track_force;
    logic [2:0] rx_pre_eq_sel;
    logic rx_pre_eq_off;
    hst_order_e recovery_loop_order;
    logic [5:0] recovery_vote_threshold;
    logic hf_peaking_off;
    logic short_channel_recovery;
    logic [4:0] tx_main_cursor_reduce;
    logic crf_reserved;
    logic rx_polarity_flip;
    logic tx_polarity_flip;
    logic [4:0] tx_post1_tap;
    logic [3:0] tx_pre_tap;
    logic [3:0] tx_post2_tap;
    logic [10:0] tx_swing_mv;
  } hst_cfg_s;

endpackage

// >>> design/hst_reg16.sv
// One 16-bit software register with a write strobe and a reset value.
// Assumes a single clock and an asynchronous active-low reset.
`timescale 1ns/1ps

module hst_reg16 #(
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK = 16'hFFFF
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic we,
  input wire logic [15:0] wdata,
  output logic [15:0] q
);

  logic [15:0] q_r;
  logic [15:0] q_nxt;

  // Load writable bits on a write, keep the rest
  always_comb begin
    q_nxt = q_r;
    if (we) begin
      q_nxt = (wdata & WR_MASK) | (q_r & ~WR_MASK);
    end
  end

  // Register with reset value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      q_r <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

  AST_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
    !we |=> q_r == $past(q_r))
    else $error("Register changed without a write");

endmodule // hst_reg16

// >>> design/hst_tuning_regs.sv
// Tuning register bank of the high-speed serializer/deserializer.
// Assumes a plain register port driven by a synchronous master on clk;
// the decoded settings statically steer the analog transceiver.
`timescale 1ns/1ps
`include "hst_map.svh"

module hst_tuning_regs (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_addr_err,
  output hst_pkg::hst_cfg_s cfg
);

  hst_pkg::hst_req_s req;
  logic [15:0] swing_q;
  logic [15:0] rx_q;
  logic [15:0] tap_q;
  logic we_swing;
  logic we_rx;
  logic we_tap;
  logic hit;
  logic [15:0] rd_mux;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic err_r;
  logic err_nxt;
  logic [10:0] swing_mv;

  // Bundle the port into one request
  assign req.addr = reg_addr;
  assign req.wdata = reg_wdata;
  assign req.wr = reg_wr;
  assign req.rd = reg_rd;

  // Address decode and write strobes
  always_comb begin
    hit = (req.addr == `HST_OFS_SWING) || (req.addr == `HST_OFS_RX_TUNING) ||
          (req.addr == `HST_OFS_TX_TAP);
    we_swing = req.wr && (req.addr == `HST_OFS_SWING);
    we_rx = req.wr && (req.addr == `HST_OFS_RX_TUNING);
    we_tap = req.wr && (req.addr == `HST_OFS_TX_TAP);
  end

  // Swing control register; other bits stored for the wider bank
  hst_reg16 #(
    .RST_VAL(`HST_RST_SWING),
    .WR_MASK(16'hFFFF)
  ) u_swing (
    .clk(clk),
    .rst_b(rst_b),
    .we(we_swing),
    .wdata(req.wdata),
    .q(swing_q)
  );

  // Receiver tuning register, all bits plain read/write
  hst_reg16 #(
    .RST_VAL(`HST_RST_RX_TUNING),
    .WR_MASK(16'hFFFF)
  ) u_rx (
    .clk(clk),
    .rst_b(rst_b),
    .we(we_rx),
    .wdata(req.wdata),
    .q(rx_q)
  );

  // Transmit tap and polarity register
  hst_reg16 #(
    .RST_VAL(`HST_RST_TX_TAP),
    .WR_MASK(16'hFFFF)
  ) u_tap (
    .clk(clk),
    .rst_b(rst_b),
    .we(we_tap),
    .wdata(req.wdata),
    .q(tap_q)
  );

  // Read mux; unmapped addresses read as zero
  always_comb begin
    case (req.addr)
      `HST_OFS_SWING: rd_mux = swing_q;
      `HST_OFS_RX_TUNING: rd_mux = rx_q;
      `HST_OFS_TX_TAP: rd_mux = tap_q;
      default: rd_mux = 16'h0000;
    endcase
  end

  // Read data and error flag, next values
  always_comb begin
    rdata_nxt = 16'h0000;
    rvalid_nxt = req.rd;
    err_nxt = (req.rd || req.wr) && !hit;
    if (req.rd) begin
      rdata_nxt = rd_mux;
    end
  end

  // Read data stand one cycle after the strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      err_r <= err_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign reg_addr_err = err_r;

  // Typical swing amplitude in millivolts for the selected code
  always_comb begin
    case (swing_q[`HST_SWING_HI:`HST_SWING_LO])
      4'h0: swing_mv = 11'h082;
      4'h1: swing_mv = 11'h0DC;
      4'h2: swing_mv = 11'h12C;
      4'h3: swing_mv = 11'h186;
      4'h4: swing_mv = 11'h1E0;
      4'h5: swing_mv = 11'h23A;
      4'h6: swing_mv = 11'h294;
      4'h7: swing_mv = 11'h2EE;
      4'h8: swing_mv = 11'h33E;
      4'h9: swing_mv = 11'h3A2;
      4'hA: swing_mv = 11'h3FC;
      4'hB: swing_mv = 11'h456;
      4'hC: swing_mv = 11'h49C;
      4'hD: swing_mv = 11'h4F6;
      4'hE: swing_mv = 11'h53C;
      4'hF: swing_mv = 11'h578;
      default: swing_mv = 11'h000;
    endcase
  end

  // Static settings toward the transceiver
  always_comb begin
    cfg.tx_swing_level = swing_q[`HST_SWING_HI:`HST_SWING_LO];
    cfg.tx_swing_mv = swing_mv;
    cfg.rx_adc_track_force = rx_q[`HST_TRACK_BIT];
    cfg.rx_pre_eq_sel = rx_q[`HST_EQPRE_HI:`HST_EQPRE_LO];
    cfg.rx_pre_eq_off =
      rx_q[`HST_EQPRE_HI:`HST_EQPRE_LO] == `HST_EQ_OFF_CODE;
    cfg.recovery_loop_order =
      hst_pkg::hst_order_e'(rx_q[`HST_ORDER_HI:`HST_ORDER_LO]);
    // Vote count is four shifted by the code
    cfg.recovery_vote_threshold =
      6'h04 << rx_q[`HST_VOTE_HI:`HST_VOTE_LO];
    cfg.hf_peaking_off = rx_q[`HST_PEAK_BIT];
    cfg.short_channel_recovery = rx_q[`HST_SHORT_BIT];
    cfg.tx_main_cursor_reduce = rx_q[`HST_CRF_HI:`HST_CRF_LO];
    cfg.crf_reserved =
      (rx_q[`HST_CRF_HI:`HST_CRF_LO] >= `HST_CRF_RSVD_LO) &&
      (rx_q[`HST_CRF_HI:`HST_CRF_LO] <= `HST_CRF_RSVD_HI);
    cfg.rx_polarity_flip = tap_q[`HST_RXPOL_BIT];
    cfg.tx_polarity_flip = tap_q[`HST_TXPOL_BIT];
    cfg.tx_post1_tap = tap_q[`HST_POST1_HI:`HST_POST1_LO];
    cfg.tx_pre_tap = tap_q[`HST_PRE_HI:`HST_PRE_LO];
    cfg.tx_post2_tap = tap_q[`HST_POST2_HI:`HST_POST2_LO];
  end

  // Reset values show right after release
  AST_RX_RESET: assert property (@(posedge clk)
    $rose(rst_b) |-> rx_q == `HST_RST_RX_TUNING)
    else $error("Receiver tuning reset value wrong");

  AST_TAP_RESET: assert property (@(posedge clk)
    $rose(rst_b) |-> tap_q[`HST_TX_RSVD_BIT] == 1'b1)
    else $error("Reserved tap bit not one after reset");

  AST_RSVD_RX: assert property (@(posedge clk)
    $rose(rst_b) |-> rx_q[`HST_RX_RSVD_BIT] == 1'b0)
    else $error("Reserved receiver bit not zero after reset");

  AST_SWING_RESET: assert property (@(posedge clk)
    $rose(rst_b) |-> cfg.tx_swing_level == 4'hA)
    else $error("Swing level reset value wrong");

  // Write then read of the receiver register with no gap returns the data
  AST_READBACK: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_RX_TUNING ##1
    reg_rd && reg_addr == `HST_OFS_RX_TUNING && !reg_wr
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("Receiver tuning readback differs from write");

  // Receiver tuning fields follow the write that loads them
  AST_TRACK: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_RX_TUNING
    |=> cfg.rx_adc_track_force == $past(reg_wdata[15]))
    else $error("Track force not following write");

  AST_EQ_OFF: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_RX_TUNING
    |=> cfg.rx_pre_eq_off == ($past(reg_wdata[14:12]) == 3'h7))
    else $error("Equalizer off flag not following code 111");

  AST_ORDER: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_RX_TUNING
    |=> cfg.recovery_loop_order == $past(reg_wdata[11:10]))
    else $error("Recovery loop order not following write");

  AST_VOTES: assert property (@(posedge clk) disable iff (!rst_b)
    rx_q[9:8] == 2'h1 |-> cfg.recovery_vote_threshold == 6'h08)
    else $error("Vote threshold for code 01 not eight");

  AST_VOTES_MIN: assert property (@(posedge clk) disable iff (!rst_b)
    rx_q[9:8] == 2'h0 |-> cfg.recovery_vote_threshold == 6'h04)
    else $error("Vote threshold for code 00 not four");

  AST_VOTES_MAX: assert property (@(posedge clk) disable iff (!rst_b)
    rx_q[9:8] == 2'h3 |-> cfg.recovery_vote_threshold == 6'h20)
    else $error("Vote threshold for code 11 not thirty-two");

  AST_RSVD_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_RX_TUNING
    |=> rx_q[`HST_RX_RSVD_BIT] == $past(reg_wdata[7]))
    else $error("Reserved receiver bit not stored as written");

  AST_PEAK: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_RX_TUNING
    |=> cfg.hf_peaking_off == $past(reg_wdata[6]))
    else $error("Peaking off not following write");

  AST_SHORT: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_RX_TUNING
    |=> cfg.short_channel_recovery == $past(reg_wdata[5]))
    else $error("Short channel mode not following write");

  AST_CRF: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_RX_TUNING
    |=> cfg.tx_main_cursor_reduce == $past(reg_wdata[4:0]))
    else $error("Cursor reduction code not following write");

  // Reduction codes in the reserved gap are flagged, upper codes are not
  AST_CRF_RSVD: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.tx_main_cursor_reduce == 5'h0B |-> cfg.crf_reserved)
    else $error("Reduction code 01011 not flagged reserved");

  AST_CRF_USED: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.tx_main_cursor_reduce == 5'h1F |-> !cfg.crf_reserved)
    else $error("Reduction code 11111 flagged reserved");

  // Upper swing codes map to their typical amplitudes
  AST_SWING_C: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.tx_swing_level == 4'hC |-> cfg.tx_swing_mv == 11'h49C)
    else $error("Swing code 1100 not 1180 mV");

  AST_SWING_D: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.tx_swing_level == 4'hD |-> cfg.tx_swing_mv == 11'h4F6)
    else $error("Swing code 1101 not 1270 mV");

  AST_SWING_E: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.tx_swing_level == 4'hE |-> cfg.tx_swing_mv == 11'h53C)
    else $error("Swing code 1110 not 1340 mV");

  AST_SWING_TOP: assert property (@(posedge clk) disable iff (!rst_b)
    cfg.tx_swing_level == 4'hF |-> cfg.tx_swing_mv == 11'h578)
    else $error("Top swing code not 1400 mV");

  AST_SWING_WR: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_SWING
    |=> cfg.tx_swing_level == $past(reg_wdata[15:12]))
    else $error("Swing level not following write");

  // Tap register fields follow the write that loads them
  AST_POL: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_TX_TAP |=>
    cfg.rx_polarity_flip == $past(reg_wdata[15]) &&
    cfg.tx_polarity_flip == $past(reg_wdata[14]))
    else $error("Polarity flips not following write");

  AST_TAP_RSVD: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_TX_TAP
    |=> tap_q[`HST_TX_RSVD_BIT] == $past(reg_wdata[13]))
    else $error("Reserved tap bit not stored as written");

  AST_POST1: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_TX_TAP
    |=> cfg.tx_post1_tap == $past(reg_wdata[12:8]))
    else $error("First post-cursor tap not following write");

  AST_PRE: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_TX_TAP
    |=> cfg.tx_pre_tap == $past(reg_wdata[7:4]))
    else $error("Pre-cursor tap not following write");

  AST_POST2: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == `HST_OFS_TX_TAP
    |=> cfg.tx_post2_tap == $past(reg_wdata[3:0]))
    else $error("Second post-cursor tap not following write");

  // Read answers stand one cycle after the strobe and are quiet otherwise
  AST_RD_VALID: assert property (@(posedge clk) disable iff (!rst_b)
    reg_rd |=> reg_rvalid)
    else $error("Read strobe without valid in the next cycle");

  AST_RD_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
    !reg_rd |=> !reg_rvalid && reg_rdata == 16'h0000)
    else $error("Read data shown without a read strobe");

  // Unmapped places raise the error flag and leave the registers alone
  AST_ADDR_ERR: assert property (@(posedge clk) disable iff (!rst_b)
    (reg_wr || reg_rd) && reg_addr > `HST_OFS_TX_TAP |=> reg_addr_err)
    else $error("Unmapped access without error flag");

  AST_WR_MISS: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr > `HST_OFS_TX_TAP |=>
    rx_q == $past(rx_q) && tap_q == $past(tap_q) &&
    swing_q == $past(swing_q))
    else $error("Unmapped write changed a register");

endmodule // hst_tuning_regs

// >>> sim/hst_tuning_regs_test.sv
// Self-checking bench for the serdes tuning register bank.
// Assumes hst_pkg and the design files are compiled before it.
`timescale 1ns/1ps

module hst_tuning_regs_test;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic reg_rvalid;
  logic reg_addr_err;
  hst_pkg::hst_cfg_s cfg;
  int failures = 0;
  int n_compared = 0;
  int mdl [3:5];
  int mv [16] = '{130, 220, 300, 390, 480, 570, 660, 750, 830, 930, 1020,
    1110, 1180, 1270, 1340, 1400};

  // Clock of 40 ns
  always #20 clk = ~clk;

  hst_tuning_regs dut (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .reg_addr_err(reg_addr_err),
    .cfg(cfg)
  );

  // Prints the counts and the verdict, then stops
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One comparison
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  // Reset held 20 cycles; the model takes the listed defaults
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    mdl[3] = 'hA848;
    mdl[4] = 'h1500;
    mdl[5] = 'h2000;
  endtask

  // Compares every decoded setting with the model
  task automatic chk_cfg();
    logic [15:0] s;
    logic [15:0] r;
    logic [15:0] t;
    s = mdl[3][15:0];
    r = mdl[4][15:0];
    t = mdl[5][15:0];
    chk("swing", s[15:12], cfg.tx_swing_level);
    chk("swing_mv", mv[s[15:12]], cfg.tx_swing_mv);
    chk("track", r[15], cfg.rx_adc_track_force);
    chk("eq_sel", r[14:12], cfg.rx_pre_eq_sel);
    chk("eq_off", r[14:12] == 3'h7, cfg.rx_pre_eq_off);
    chk("order", r[11:10], cfg.recovery_loop_order);
    chk("votes", 4 << r[9:8], cfg.recovery_vote_threshold);
    chk("peak_off", r[6], cfg.hf_peaking_off);
    chk("short", r[5], cfg.short_channel_recovery);
    chk("crf", r[4:0], cfg.tx_main_cursor_reduce);
    chk("crf_rsvd", r[4:0] >= 7 && r[4:0] <= 15, cfg.crf_reserved);
    chk("rx_pol", t[15], cfg.rx_polarity_flip);
    chk("tx_pol", t[14], cfg.tx_polarity_flip);
    chk("post1", t[12:8], cfg.tx_post1_tap);
    chk("pre", t[7:4], cfg.tx_pre_tap);
    chk("post2", t[3:0], cfg.tx_post2_tap);
  endtask

  // Write cycle, then error flag and decoded settings
  task automatic wr(logic [7:0] a, logic [15:0] d);
    logic hit;
    hit = a >= 8'h03 && a <= 8'h05;
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
    if (hit) mdl[a] = d;
    chk("wr_err", !hit, reg_addr_err);
    chk_cfg();
  endtask

  // Read cycle; data stand in the next cycle only
  task automatic rd(logic [7:0] a);
    logic hit;
    hit = a >= 8'h03 && a <= 8'h05;
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("rvalid", 1, reg_rvalid);
    chk("rdata", hit ? mdl[a][15:0] : 16'h0000, reg_rdata);
    chk("rd_err", !hit, reg_addr_err);
    @(posedge clk);
    #1;
    chk("rvalid_end", 0, reg_rvalid);
    chk("rdata_end", 16'h0000, reg_rdata);
  endtask

  // Reads the three registers and the decode
  task automatic rd_all();
    rd(8'h03);
    rd(8'h04);
    rd(8'h05);
    chk_cfg();
  endtask

  // Write and read of one mapped place with no gap between the strobes
  task automatic wr_rd(logic [7:0] a, logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    mdl[a] = d;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("b2b_rvalid", 1, reg_rvalid);
    chk("b2b_rdata", mdl[a][15:0], reg_rdata);
    chk_cfg();
  endtask

  // Main sequence
  initial begin
    logic [15:0] d;
    void'($urandom(77));
    do_reset();
    rd_all();
    // Every multi-bit field code; reserved, track, peaking and short-channel bits left random
    for (int k = 0; k < 32; k++) begin
      d = 16'($urandom);
      wr(8'h04, {d[15], k[2:0], k[1:0], k[1:0], d[7:5], k[4:0]});
      wr(8'h03, {k[3:0], d[11:0]});
      wr(8'h05, {k[1:0], d[13], k[4:0], k[3:0], k[3:0]});
      rd(8'h05);
    end
    // Random traffic on mapped places, also with back-to-back strobes
    for (int i = 0; i < 40; i++) begin
      d = 16'($urandom);
      wr(8'h03 + 8'($urandom_range(2)), d);
      rd(8'h03 + 8'($urandom_range(2)));
      wr_rd(8'h04, ~d);
      wr_rd(8'h03 + 8'($urandom_range(2)), 16'($urandom));
    end
    // Unmapped places refuse writes and read zero
    foreach (mdl[j]) begin
      wr(8'($urandom_range(255, 6)), 16'($urandom));
      wr(8'($urandom_range(2)), 16'($urandom));
      rd(8'($urandom_range(255, 6)));
    end
    rd_all();
    // Reset in mid-run restores the defaults
    wr(8'h05, 16'hDFFF);
    do_reset();
    #1;
    chk_cfg();
    rd_all();
    end_of_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #(40 * 6000);
    failures++;
    end_of_test();
  end
endmodule // hst_tuning_regs_test
